// >>> rtl/lw_sram_pkg.sv
// constants shared by the late-write static ram port and its parts
// assumes a single 125 MHz clock and an apb register window
package lw_sram_pkg;
    localparam int ADDR_W  = 17;    // word address bits
    localparam int LANES   = 4;     // byte lanes per word
    localparam int LANE_W  = 9;     // bits per byte lane
    localparam int IMP_W   = 6;     // impedance code width
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] WCOUNT_OFS = 12'h008;
    // field positions in status
    localparam int ST_IMP_LSB = 0;
    localparam int ST_DWELL   = 8;
    localparam int ST_WBUF    = 9;
    // reset values
    localparam logic [5:0] IMP_RESET = 6'h20;
    // power-up dwell, least time rounds up
    localparam int CLK_MHZ   = 125;
    localparam int DWELL_NS  = 1000;
    localparam int DWELL_CYC = (DWELL_NS * CLK_MHZ + 999) / 1000;
    localparam int DWELL_W   = 8;
endpackage

// >>> rtl/lw_mem_if.sv
// array port between the controller core and its storage
// assumes one clock, writes and reads in the same cycle allowed
`timescale 1ns/1ps
`default_nettype none
interface lw_mem_if #(parameter int AW = 17, parameter int LN = 4, parameter int LW = 9);
    logic             we;
    logic [AW-1:0]    waddr;
    logic [LN-1:0]    wmask;
    logic [LN*LW-1:0] wdata;
    logic             re;
    logic [AW-1:0]    raddr;
    logic [LN*LW-1:0] rdata;
    modport core (output we, waddr, wmask, wdata, re, raddr, input rdata);
    modport array (input we, waddr, wmask, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

// >>> rtl/lw_mem_array.sv
// storage array with per-lane write mask and registered read data
// assumes synchronous single-clock use; a same-cycle write forwards
`timescale 1ns/1ps
`default_nettype none
module lw_mem_array #(
    parameter int AW = 17,
    parameter int LN = 4,
    parameter int LW = 9
) (
    input  wire logic clk,
    lw_mem_if.array   mp
);
    initial begin
        if (AW < 1 || LN < 1 || LW < 1) $error("bad array geometry");
    end

    for (genvar l = 0; l < LN; l++) begin : g_lane
        logic [LW-1:0] store [0:(1<<AW)-1];
        // lane write
        always_ff @(posedge clk) begin
            if (mp.we && mp.wmask[l]) begin
                store[mp.waddr] <= mp.wdata[l*LW +: LW];
            end
        end
        // write-first read so a commit never hides behind a read
        always_ff @(posedge clk) begin
            if (mp.re) begin
                if (mp.we && mp.wmask[l] && mp.waddr == mp.raddr) begin
                    mp.rdata[l*LW +: LW] <= mp.wdata[l*LW +: LW];
                end else begin
                    mp.rdata[l*LW +: LW] <= store[mp.raddr];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/lw_write_buffer.sv
// single-stage write buffer with address comparator and lane merge
// assumes load pulses come one cycle after the write was registered
`timescale 1ns/1ps
`default_nettype none
module lw_write_buffer #(
    parameter int AW = 17,
    parameter int LN = 4,
    parameter int LW = 9
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [AW-1:0]    load_addr,
    input  wire logic [LN-1:0]    load_mask,
    input  wire logic [LN*LW-1:0] load_data,
    input  wire logic [AW-1:0]    look_addr,
    input  wire logic [LN*LW-1:0] arr_data,
    output logic [LN*LW-1:0]      merged,
    output logic                  held,
    lw_mem_if.core                mp
);
    logic [AW-1:0]    buf_addr;
    logic [LN-1:0]    buf_mask;
    logic [LN*LW-1:0] buf_data;
    logic             hit;

    // buffer load; old contents leave through the commit port
    always_ff @(posedge clk) begin
        if (rst) begin
            held <= 1'b0;
        end else if (load) begin
            held <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (load) begin
            buf_addr <= load_addr;
            buf_mask <= load_mask;
            buf_data <= load_data;
        end
    end

    // commit of the previous write on every new load
    assign mp.we    = load && held;
    assign mp.waddr = buf_addr;
    assign mp.wmask = buf_mask;
    assign mp.wdata = buf_data;

    // comparator: buffered lanes override the array copy
    assign hit = held && (buf_addr == look_addr);
    for (genvar l = 0; l < LN; l++) begin : g_merge
        assign merged[l*LW +: LW] = (hit && buf_mask[l]) ? buf_data[l*LW +: LW]
                                                          : arr_data[l*LW +: LW];
    end
endmodule
`default_nettype wire

// >>> rtl/lw_sram_port.sv
// late-write synchronous static ram port with apb control window
// assumes the controller keeps the dead cycle before writes and the dwell
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - address, select, write and lane enables registered every rising edge
// - read data loads the output register on the edge after the read
// - a new read address is accepted while the previous data is delivered
// - a read may follow a write with no idle cycle
// - select registered high drops the drivers only after the next edge
// - write registered low drops the drivers in the same cycle
// - select low with write high changes drive only after the next edge
// - output enable gates the drivers with no clock, active low
// - data bus split into nine-bit lanes, each with its own write enable
// - lane enables are ignored on reads, all lanes are returned
// - a write with all lanes enabled updates the whole word
// - a write cycle never reads any lane at that address
// - a write with no lane enabled changes nothing but the write count, and drops the drivers
// - address taken on the write edge, data on the following edge
// - reads hitting the buffered address return the buffered lanes
// - programmed impedance is applied only during deselect cycles
// - buffered writes need no extra cycles or signals from the controller
module lw_sram_port #(
    parameter int ADDR_W = lw_sram_pkg::ADDR_W,
    parameter int LANES  = lw_sram_pkg::LANES,
    parameter int LANE_W = lw_sram_pkg::LANE_W
) (
    input  wire logic                      MCLK_IN,
    input  wire logic                      RESET_IN,
    input  wire logic                      PSEL_IN,
    input  wire logic                      PENABLE_IN,
    input  wire logic                      PWRITE_IN,
    input  wire logic [11:0]               PADDR_IN,
    input  wire logic [31:0]               PWDATA_IN,
    output logic      [31:0]               PRDATA_OUT,
    output logic                           PREADY_OUT,
    output logic                           PSLVERR_OUT,
    input  wire logic [ADDR_W-1:0]         ADDR_IN,
    input  wire logic                      SYNC_SEL_N_IN,
    input  wire logic                      SYNC_WRITE_N_IN,
    input  wire logic [LANES-1:0]          LANE_WRITE_EN_N_IN,
    input  wire logic                      OUT_EN_N_IN,
    input  wire logic [LANES*LANE_W-1:0]   DQ_IN,
    output logic      [LANES*LANE_W-1:0]   DQ_OUT,
    output logic                           DQ_OE_OUT,
    output logic      [lw_sram_pkg::IMP_W-1:0] IMPEDANCE_OUT
);
    localparam int DW = LANES * LANE_W;

    initial begin
        if (LANE_W != 9) $error("lanes must be nine bits wide");
        if (LANES < 1 || LANES > 8) $error("lane count out of range");
        if (ADDR_W < 1 || ADDR_W > 24) $error("address width out of range");
    end

    // registered view of the current cycle
    logic              rd_q;
    logic [ADDR_W-1:0] addr_q;
    logic              pend_q;
    logic [LANES-1:0]  pend_mask;
    logic              drive_q;
    logic              desel_q;
    logic              rd_now;
    logic              wr_now;

    // apb state
    logic [lw_sram_pkg::IMP_W-1:0] imp_target;
    logic [lw_sram_pkg::DWELL_W-1:0] dwell_cnt;
    logic                          dwell_done;
    logic [15:0]                   wr_count;
    logic                          apb_access;
    logic [31:0]                   next_rdata;
    logic                          next_err;

    // buffer and array
    logic [DW-1:0] arr_data;
    logic [DW-1:0] merged;
    logic          buf_held;

    lw_mem_if #(.AW(ADDR_W), .LN(LANES), .LW(LANE_W)) mif ();

    // cycle decode straight from the pins, which are synchronous
    // read accepted right after write
    assign rd_now = !SYNC_SEL_N_IN && SYNC_WRITE_N_IN;
    assign wr_now = !SYNC_SEL_N_IN && !SYNC_WRITE_N_IN;

    // capture control
    // every control pin except the output enable and the lane enables lands in a flop here
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            rd_q    <= 1'b0;
            desel_q <= 1'b1;
        end else begin
            rd_q    <= rd_now;
            desel_q <= SYNC_SEL_N_IN;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        addr_q <= ADDR_IN;
    end

    // late write stage
    // address and lanes wait here one edge for their data
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            pend_q    <= 1'b0;
            pend_mask <= '0;
        end else begin
            pend_q    <= wr_now;
            // all lanes give the full word
            pend_mask <= wr_now ? ~LANE_WRITE_EN_N_IN : '0;
        end
    end

    // array read straight from the pin address
    // reading on the registering edge keeps reads back to back
    assign mif.re    = rd_now;
    assign mif.raddr = ADDR_IN;
    assign arr_data  = mif.rdata;

    lw_mem_array #(
        .AW (ADDR_W),
        .LN (LANES),
        .LW (LANE_W)
    ) u_array (
        .clk (MCLK_IN),
        .mp  (mif.array)
    );

    // an empty lane mask never reaches the buffer
    lw_write_buffer #(
        .AW (ADDR_W),
        .LN (LANES),
        .LW (LANE_W)
    ) u_wbuf (
        .clk       (MCLK_IN),
        .rst       (RESET_IN),
        .load      (pend_q && (pend_mask != '0)),
        .load_addr (addr_q),
        .load_mask (pend_mask),
        .load_data (DQ_IN),
        .look_addr (addr_q),
        .arr_data  (arr_data),
        .merged    (merged),
        .held      (buf_held),
        .mp        (mif.core)
    );

    // buffered lanes win over the array
    // all lanes returned on a read
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            DQ_OUT <= '0;
        end else if (rd_q) begin
            DQ_OUT <= merged;
        end
    end

    // a write pin low kills drive at its own edge
    // read drive starts one edge late
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= rd_q && SYNC_WRITE_N_IN;
        end
    end

    // asynchronous output enable
    // the only output not from a flop, as the pin must not wait for an edge
    assign DQ_OE_OUT = drive_q && !OUT_EN_N_IN;

    // power-up dwell counter, reported in status only
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            dwell_cnt  <= '0;
            dwell_done <= 1'b0;
        end else if (!dwell_done) begin
            dwell_cnt  <= dwell_cnt + 1'b1;
            dwell_done <= (dwell_cnt ==
                           lw_sram_pkg::DWELL_W'(lw_sram_pkg::DWELL_CYC - 1));
        end
    end

    // impedance update on deselect
    // applying it mid-burst would disturb driven data
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            IMPEDANCE_OUT <= lw_sram_pkg::IMP_RESET;
        end else if (desel_q) begin
            IMPEDANCE_OUT <= imp_target;
        end
    end

    // write cycle counter for software
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            wr_count <= '0;
        end else if (wr_now) begin
            wr_count <= wr_count + 1'b1;
        end
    end

    // apb: no wait state, answer registered
    assign apb_access = PSEL_IN && PENABLE_IN && PREADY_OUT;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (PADDR_IN)
            lw_sram_pkg::CTRL_OFS: begin
                next_rdata[lw_sram_pkg::IMP_W-1:0] = imp_target;
            end
            lw_sram_pkg::STATUS_OFS: begin
                next_rdata[lw_sram_pkg::ST_IMP_LSB +: lw_sram_pkg::IMP_W] =
                    IMPEDANCE_OUT;
                next_rdata[lw_sram_pkg::ST_DWELL] = dwell_done;
                next_rdata[lw_sram_pkg::ST_WBUF]  = buf_held;
            end
            lw_sram_pkg::WCOUNT_OFS: begin
                next_rdata[15:0] = wr_count;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // apb handshake and read data
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
            PRDATA_OUT  <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? next_rdata
                                                                  : 32'h0000_0000;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && next_err;
        end
    end

    // control register write
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            imp_target <= lw_sram_pkg::IMP_RESET;
        end else if (apb_access && PWRITE_IN && PADDR_IN == lw_sram_pkg::CTRL_OFS) begin
            imp_target <= PWDATA_IN[lw_sram_pkg::IMP_W-1:0];
        end
    end

    // checks guard the pin timing against its cause
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RESET_IN);

    logic [DW-1:0] exp_word;
    logic          exp_live;
    logic [ADDR_W-1:0] exp_addr;

    // helper: the last full-width write, kept for reads of its address until the next write
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            exp_live <= 1'b0;
        end else if (pend_q && pend_mask == '1) begin
            exp_live <= 1'b1;
            exp_word <= DQ_IN;
            exp_addr <= addr_q;
        end else if (pend_q) begin
            exp_live <= 1'b0;
        end
    end

    a_read_drive_on: assert property (
        rd_now ##1 SYNC_WRITE_N_IN |=> drive_q)
        else $error("read did not drive on the next edge");

    a_write_drive_off: assert property (
        !SYNC_WRITE_N_IN |=> !drive_q)
        else $error("write did not drop drive at once");

    a_desel_drive_late: assert property (
        rd_q && SYNC_SEL_N_IN && SYNC_WRITE_N_IN |=> drive_q ##1 !drive_q)
        else $error("deselect dropped drive at the wrong edge");

    a_oe_gates_pins: assert property (
        OUT_EN_N_IN |-> !DQ_OE_OUT)
        else $error("drivers on while output enable high");

    a_read_after_write: assert property (
        exp_live && rd_q && addr_q == exp_addr |=> DQ_OUT == exp_word)
        else $error("read after write returned stale data");

    a_empty_write_quiet: assert property (
        wr_now && LANE_WRITE_EN_N_IN == '1 |=> pend_q && pend_mask == '0 && !mif.we)
        else $error("empty lane write touched the buffer");

    a_commit_on_load: assert property (
        pend_q && pend_mask != '0 && buf_held |-> mif.we)
        else $error("previous write not committed");

    a_imp_on_desel: assert property (
        $changed(IMPEDANCE_OUT) |-> $past(desel_q))
        else $error("impedance changed outside a deselect cycle");

    a_late_data_take: assert property (
        wr_now && LANE_WRITE_EN_N_IN != '1 |=> ##1 buf_held)
        else $error("write data not taken on following edge");

    a_dq_hold_idle: assert property (
        !rd_q |=> $stable(DQ_OUT))
        else $error("output register moved without a read");

    a_full_lane_take: assert property (
        wr_now && LANE_WRITE_EN_N_IN == '0 |=> pend_q && pend_mask == '1)
        else $error("full write did not enable every lane");

    a_read_no_mask: assert property (
        rd_now |=> !pend_q && pend_mask == '0)
        else $error("lane enables acted on a read");

    a_read_after_wr: assert property (
        wr_now ##1 rd_now |=> rd_q && !drive_q)
        else $error("read right after write not accepted");

    a_write_no_read: assert property (
        wr_now |-> !mif.re)
        else $error("write cycle also read the array");

    a_apb_ready_one: assert property (
        PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("apb ready not a single cycle");
endmodule
`default_nettype wire

// >>> testbench/lw_ctrl_model.sv
// controller model for the sram side of the late-write port
// assumes the bench calls cyc once per clock, right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module lw_ctrl_model (
    input  wire logic        clk_in,
    input  wire logic [35:0] dq_rd_in,
    input  wire logic        dq_oe_in,
    output logic      [16:0] addr_out,
    output logic             sel_n_out,
    output logic             write_n_out,
    output logic      [3:0]  lane_n_out,
    output logic      [35:0] dq_wr_out
);
    logic        pend;    // write data owed next cycle
    logic [35:0] pdata;
    logic        last_rd;
    logic [35:0] q;       // read bus seen mid-cycle
    logic        qoe;

    // start deselected
    initial begin
        addr_out = 17'h00000;
        sel_n_out = 1'b1;
        write_n_out = 1'b1;
        lane_n_out = 4'hF;
        dq_wr_out = 36'h000000000;
        pend = 1'b0;
        pdata = 36'h000000000;
        last_rd = 1'b0;
    end

    // one clock of commands, bus looked at on the falling edge
    task step(input logic s, input logic w, input logic [3:0] ln,
              input logic [16:0] a, input logic [35:0] d);
        sel_n_out <= s;
        write_n_out <= w;
        lane_n_out <= ln;
        addr_out <= a;
        // data one cycle late
        // released lines toggle so stale data never looks valid
        dq_wr_out <= pend ? pdata : ~dq_wr_out;
        pend = !s && !w;
        pdata = d;
        last_rd = !s && w;
        @(negedge clk_in);
        q = dq_rd_in;
        qoe = dq_oe_in;
        @(posedge clk_in);
    endtask

    task cyc(input logic s, input logic w, input logic [3:0] ln,
             input logic [16:0] a, input logic [35:0] d);
        if (!s && !w && last_rd)
            step(1'b1, 1'b1, 4'hF, a, d);
        step(s, w, ln, a, d);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the late-write sram port
// assumes the controller model above and the apb window of the port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [16:0] a_lo = 17'h00010;
    localparam logic [16:0] a_hi = 17'h1FFFF;
    localparam logic [35:0] w1 = 36'h123456789;
    localparam logic [35:0] w2 = 36'h9ABCDEF01;
    localparam logic [35:0] w3 = 36'h0F0F0F0F0;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [16:0] addr;
    logic        sel_n;
    logic        write_n;
    logic [3:0]  lane_n;
    logic        out_en_n;
    logic [35:0] dq_wr;
    logic [35:0] dq_rd;
    logic        dq_oe;
    logic [5:0]  imp;
    logic [31:0] r;
    logic        e;
    int          err_count;
    int          checks;
    int          cycles;

    lw_sram_port lw_sram_port_i (.MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ADDR_IN(addr),
        .SYNC_SEL_N_IN(sel_n), .SYNC_WRITE_N_IN(write_n), .LANE_WRITE_EN_N_IN(lane_n),
        .OUT_EN_N_IN(out_en_n), .DQ_IN(dq_wr), .DQ_OUT(dq_rd), .DQ_OE_OUT(dq_oe),
        .IMPEDANCE_OUT(imp));
    lw_ctrl_model lw_ctrl_model_i (.clk_in(clk), .dq_rd_in(dq_rd), .dq_oe_in(dq_oe),
        .addr_out(addr), .sel_n_out(sel_n), .write_n_out(write_n), .lane_n_out(lane_n),
        .dq_wr_out(dq_wr));

    always #4 clk = ~clk;

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk_word(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // apb transfer; a trailing edge keeps psel from being set twice at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        // pready high ends this wait; the bench hang guard bounds it
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [16:0] a, input logic [3:0] ln);
        lw_ctrl_model_i.cyc(1'b0, 1'b1, ln, a, 36'h000000000);
    endtask

    task wr(input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
        lw_ctrl_model_i.cyc(1'b0, 1'b0, ln, a, d);
    endtask

    task ds;
        lw_ctrl_model_i.cyc(1'b1, 1'b1, 4'hF, 17'h00000, 36'h000000000);
    endtask

    // expected word after a lane-masked write over an old word
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                          input logic [3:0] ln);
        logic [35:0] m;
        m = old;
        for (int l = 0; l < 4; l++)
            if (!ln[l])
                m[9*l +: 9] = nw[9*l +: 9];
        return m;
    endfunction

    task t_regs;
        apb(1'b0, lw_sram_pkg::CTRL_OFS, 32'h0);
        chk_word({4'h0, r}, 36'h000000020);
        apb(1'b0, lw_sram_pkg::STATUS_OFS, 32'h0);
        chk_word({4'h0, r}, 36'h000000020);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        chk_bit(e, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk_bit(e, 1'b1);
        chk_word({4'h0, r}, 36'h000000000);
        repeat (130) ds();
        apb(1'b0, lw_sram_pkg::STATUS_OFS, 32'h0);
        chk_word({4'h0, r}, 36'h000000120);
    endtask

    task t_late_write;
        wr(a_lo, 4'h0, w1);
        rd(a_lo, 4'hF);
        chk_bit(lw_ctrl_model_i.qoe, 1'b0);
        ds();
        chk_bit(lw_ctrl_model_i.qoe, 1'b0);
        ds();
        chk_word(lw_ctrl_model_i.q, w1);
        chk_bit(lw_ctrl_model_i.qoe, 1'b1);
        ds();
        chk_bit(lw_ctrl_model_i.qoe, 1'b0);
    endtask

    task t_byte_lanes;
        wr(a_hi, 4'h0, w2);
        wr(a_hi, 4'hA, w3);
        rd(a_hi, 4'hF);
        ds();
        ds();
        chk_word(lw_ctrl_model_i.q, merge(w2, w3, 4'hA));
        wr(a_lo, 4'hF, ~w1);
        rd(a_lo, 4'h0);
        chk_bit(lw_ctrl_model_i.qoe, 1'b0);
        rd(a_hi, 4'h0);
        ds();
        chk_word(lw_ctrl_model_i.q, w1);
        ds();
        chk_word(lw_ctrl_model_i.q, merge(w2, w3, 4'hA));
    endtask

    task t_out_enable;
        rd(a_lo, 4'h0);
        rd(a_lo, 4'h0);
        out_en_n <= 1'b1;
        rd(a_lo, 4'h0);
        chk_bit(lw_ctrl_model_i.qoe, 1'b0);
        chk_word(lw_ctrl_model_i.q, w1);
        out_en_n <= 1'b0;
        ds();
        chk_bit(lw_ctrl_model_i.qoe, 1'b1);
    endtask

    task t_impedance;
        fork
            apb(1'b1, lw_sram_pkg::CTRL_OFS, 32'h00000015);
            repeat (8) rd(a_lo, 4'hF);
        join
        chk_word({30'h0, imp}, 36'h000000020);
        ds();
        ds();
        ds();
        chk_word({30'h0, imp}, 36'h000000015);
        apb(1'b0, lw_sram_pkg::STATUS_OFS, 32'h0);
        chk_word({30'h0, r[5:0]}, 36'h000000015);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        out_en_n = 1'b0;
        err_count = 0;
        checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_late_write;
        t_byte_lanes;
        t_out_enable;
        t_impedance;
        tally_and_finish;
    end
endmodule
`default_nettype wire
